// >>> common/printer_parallel_port_consts.svh
// Offsets, field positions and reset values of the printer parallel port
`ifndef PRINTER_PARALLEL_PORT_CONSTS_SVH
`define PRINTER_PARALLEL_PORT_CONSTS_SVH

// Register byte offsets, one aligned word each
`define PPP_OFF_DATA 5'h00
`define PPP_OFF_STATUS 5'h04
`define PPP_OFF_CONTROL 5'h08
`define PPP_OFF_IRQ_STATUS 5'h0c
`define PPP_OFF_IRQ_MASK 5'h10

// Control register fields (a one in bits 0 to 3 pulls its open-drain line low)
`define PPP_CTL_STROBE 0
`define PPP_CTL_AUTOFEED 1
`define PPP_CTL_INIT 2
`define PPP_CTL_SELECT 3
`define PPP_CTL_IRQ_EN 4

// Status register fields
`define PPP_ST_FAULT 0
`define PPP_ST_PAPER_OUT 1
`define PPP_ST_ONLINE 2
`define PPP_ST_BUSY 3
`define PPP_ST_ACK_HIGH 4
`define PPP_ST_IRQ 5

// Interrupt status and mask fields
`define PPP_IRQ_ACK 0
`define PPP_IRQ_FAULT 1
`define PPP_IRQ_READY 2

// Reset values
`define PPP_RST_CONTROL 8'h00
`define PPP_RST_DATA 8'h00
`define PPP_RST_IRQ 3'h0
// Synchroniser fill: each pin's idle level, so no false edge follows reset
`define PPP_RST_SYNC 14'h31ff

`endif

// >>> common/printer_parallel_port_pkg.sv
// Types shared by the printer parallel port
package printer_parallel_port_pkg;
    typedef logic [7:0] pbyte_t;
    typedef logic [2:0] irqvec_t;
    typedef logic [4:0] busaddr_t;
endpackage

// >>> hdl/printer_parallel_port.sv
// Printer parallel port with an Avalon-MM register slave
// What this block does
// - Fault input is active low; fault reported while the printer holds it low.
// - Initialise line is open drain, pulled low to start printer initialisation.
// - Interrupt output is raised on a rising edge of acknowledge.
// - Interrupt output is enabled by bit 4 of the control register and, per source, by the interrupt mask.
// - Selected reads present the addressed register's status or data on the bus.
// - Selected writes load control words or data into the addressed register.
// - Drive-enable low puts the write data register onto the data lines.
// - Drive-enable high releases all data lines so they act as inputs.
// - One byte-wide data path usable in either direction.
// - Paper-out high means the printer ran out of paper.
// - Online high means the printer is selected.
// - Select line is open drain, pulled low to select the printer.
// - Strobe line is open drain, pulled low so the printer latches data.
// - Reset clears registers and puts outputs into defined states.
// - Acknowledge low confirms a transfer; interrupt fires on return high.
// - Busy high means the printer cannot accept data.
// - Accesses reach the port only while its select input is active.
// - Autofeed line is open drain, pulled low to autofeed continuous paper.
`include "printer_parallel_port_consts.svh"

module printer_parallel_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic parallel_port_select_n,
    // Printer status inputs
    input wire logic ack_n,
    input wire logic busy,
    input wire logic paper_out,
    input wire logic printer_online,
    input wire logic fault_n,
    input wire logic pd_drive_enable_n,
    // Bidirectional data lines
    input wire logic [7:0] printer_data_lines_in,
    output logic [7:0] printer_data_lines_out,
    output logic printer_data_lines_oe,
    // Open-drain control lines, output level always low
    output logic data_latch_strobe_n_out,
    output logic data_latch_strobe_n_oe,
    output logic autofeed_n_out,
    output logic autofeed_n_oe,
    output logic init_n_out,
    output logic init_n_oe,
    output logic printer_select_n_out,
    output logic printer_select_n_oe,
    // Interrupt
    output logic parallel_irq,
    output logic parallel_irq_oe
);

    localparam int SyncW = 14;

    // Synchroniser stages and edge history
    logic [SyncW-1:0] sync1_r;
    logic [SyncW-1:0] sync2_r;
    logic ackPrev_r;
    logic faultPrev_r;
    logic busyPrev_r;
    // Register file
    printer_parallel_port_pkg::pbyte_t writeData_r;
    printer_parallel_port_pkg::pbyte_t control_r;
    printer_parallel_port_pkg::irqvec_t irqStatus_r;
    printer_parallel_port_pkg::irqvec_t irqStatus_nxt;
    printer_parallel_port_pkg::irqvec_t irqMask_r;
    printer_parallel_port_pkg::irqvec_t irqEvent;
    // Bus handshake
    logic waitReq_r;
    logic [31:0] readData_r;
    logic [31:0] readWord;
    logic selected;
    logic writeNow;
    logic wrLane;
    // Synchronised inputs
    logic ackS;
    logic busyS;
    logic paperS;
    logic onlineS;
    logic faultS_n;
    logic pdEnS_n;
    printer_parallel_port_pkg::pbyte_t pdInS;
    printer_parallel_port_pkg::pbyte_t statusByte;
    // Output flops
    logic [7:0] pdOut_r;
    logic pdOe_r;
    logic strobeOe_r;
    logic autofeedOe_r;
    logic initOe_r;
    logic selectOe_r;
    logic irq_r;
    logic irqOe_r;

    // Every pin input passes two flops; only sync2_r is read by logic
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_r <= `PPP_RST_SYNC;
            sync2_r <= `PPP_RST_SYNC;
        end else begin
            sync1_r <= {pd_drive_enable_n, fault_n, printer_online, paper_out, busy, ack_n,
                        printer_data_lines_in};
            sync2_r <= sync1_r;
        end
    end

    assign pdInS = sync2_r[7:0];
    assign ackS = sync2_r[8];
    assign busyS = sync2_r[9];
    assign paperS = sync2_r[10];
    assign onlineS = sync2_r[11];
    assign faultS_n = sync2_r[12];
    assign pdEnS_n = sync2_r[13];

    // Edge history for event detection
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ackPrev_r <= 1'b1;
            faultPrev_r <= 1'b1;
            busyPrev_r <= 1'b0;
        end else begin
            ackPrev_r <= ackS;
            faultPrev_r <= faultS_n;
            busyPrev_r <= busyS;
        end
    end

    // Events: ack return high, fault going active, busy dropping
    always_comb begin
        irqEvent = '0;
        irqEvent[`PPP_IRQ_ACK] = ackS & ~ackPrev_r;
        irqEvent[`PPP_IRQ_FAULT] = ~faultS_n & faultPrev_r;
        irqEvent[`PPP_IRQ_READY] = ~busyS & busyPrev_r;
    end

    // Status byte as software sees it
    always_comb begin
        statusByte = '0;
        statusByte[`PPP_ST_FAULT] = ~faultS_n;
        statusByte[`PPP_ST_PAPER_OUT] = paperS;
        statusByte[`PPP_ST_ONLINE] = onlineS;
        statusByte[`PPP_ST_BUSY] = busyS;
        statusByte[`PPP_ST_ACK_HIGH] = ackS;
        statusByte[`PPP_ST_IRQ] = irq_r;
    end

    // Only the low byte lane carries register data
    assign selected = ~parallel_port_select_n;
    assign wrLane = avs_byteenable[0];
    assign writeNow = avs_write & ~waitReq_r & selected & wrLane;

    // Read multiplexer; unmapped offsets and unselected reads return zero
    always_comb begin
        readWord = '0;
        if (selected) begin
            unique case (avs_address)
                `PPP_OFF_DATA: readWord[7:0] = pdInS;
                `PPP_OFF_STATUS: readWord[7:0] = statusByte;
                `PPP_OFF_CONTROL: readWord[7:0] = control_r;
                `PPP_OFF_IRQ_STATUS: readWord[2:0] = irqStatus_r;
                `PPP_OFF_IRQ_MASK: readWord[2:0] = irqMask_r;
                default: readWord = '0;
            endcase
        end
    end

    // One wait cycle per access; deselected accesses still complete so the bus never hangs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            waitReq_r <= 1'b1;
            readData_r <= '0;
        end else begin
            if ((avs_read | avs_write) & waitReq_r) begin
                waitReq_r <= 1'b0;
                readData_r <= readWord;
            end else begin
                waitReq_r <= 1'b1;
            end
        end
    end

    // Write data register and control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            writeData_r <= `PPP_RST_DATA;
            control_r <= `PPP_RST_CONTROL;
        end else if (writeNow) begin
            if (avs_address == `PPP_OFF_DATA) begin
                writeData_r <= avs_writedata[7:0];
            end
            if (avs_address == `PPP_OFF_CONTROL) begin
                control_r <= avs_writedata[7:0];
            end
        end
    end

    // Sticky interrupt flags: a new event wins over a write-one clear
    always_comb begin
        irqStatus_nxt = irqStatus_r;
        if (writeNow && avs_address == `PPP_OFF_IRQ_STATUS) begin
            irqStatus_nxt = irqStatus_r & ~avs_writedata[2:0];
        end
        irqStatus_nxt = irqStatus_nxt | irqEvent;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irqStatus_r <= `PPP_RST_IRQ;
            irqMask_r <= `PPP_RST_IRQ;
        end else begin
            irqStatus_r <= irqStatus_nxt;
            if (writeNow && avs_address == `PPP_OFF_IRQ_MASK) begin
                irqMask_r <= avs_writedata[2:0];
            end
        end
    end

    // Interrupt level and its three-state enable, both gated by the enable bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
            irqOe_r <= 1'b0;
        end else begin
            irq_r <= (|(irqStatus_r & irqMask_r)) & control_r[`PPP_CTL_IRQ_EN];
            irqOe_r <= control_r[`PPP_CTL_IRQ_EN];
        end
    end

    // Data lines follow the synchronised drive enable, costing three cycles of latency from the pin
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pdOut_r <= '0;
            pdOe_r <= 1'b0;
        end else begin
            pdOut_r <= writeData_r;
            pdOe_r <= ~pdEnS_n;
        end
    end

    // Open-drain lines: enable high pulls low, released lines float to the pull-up
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobeOe_r <= 1'b0;
            autofeedOe_r <= 1'b0;
            initOe_r <= 1'b0;
            selectOe_r <= 1'b0;
        end else begin
            strobeOe_r <= control_r[`PPP_CTL_STROBE];
            autofeedOe_r <= control_r[`PPP_CTL_AUTOFEED];
            initOe_r <= control_r[`PPP_CTL_INIT];
            selectOe_r <= control_r[`PPP_CTL_SELECT];
        end
    end

    // Output connections
    assign avs_readdata = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign printer_data_lines_out = pdOut_r;
    assign printer_data_lines_oe = pdOe_r;
    assign data_latch_strobe_n_out = 1'b0;
    assign data_latch_strobe_n_oe = strobeOe_r;
    assign autofeed_n_out = 1'b0;
    assign autofeed_n_oe = autofeedOe_r;
    assign init_n_out = 1'b0;
    assign init_n_oe = initOe_r;
    assign printer_select_n_out = 1'b0;
    assign printer_select_n_oe = selectOe_r;
    assign parallel_irq = irq_r;
    assign parallel_irq_oe = irqOe_r;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence accessStart;
        (avs_read | avs_write) && waitReq_r;
    endsequence

    sequence statusRead;
        avs_read && waitReq_r && selected && avs_address == `PPP_OFF_STATUS;
    endsequence

    sequence dataWrite;
        avs_write && !waitReq_r && selected && wrLane && avs_address == `PPP_OFF_DATA;
    endsequence

    a_ack_rise_flag: assert property ($rose(ackS) |=> irqStatus_r[`PPP_IRQ_ACK])
        else $error("ack rising edge did not set its flag");

    a_ack_irq_out: assert property (
        $rose(ackS) && control_r[`PPP_CTL_IRQ_EN] && irqMask_r[`PPP_IRQ_ACK] && !writeNow ##1
        control_r[`PPP_CTL_IRQ_EN] |=> parallel_irq)
        else $error("ack rising edge did not raise the interrupt");

    a_irq_gated_off: assert property (!control_r[`PPP_CTL_IRQ_EN] [*2] |-> !parallel_irq && !parallel_irq_oe)
        else $error("interrupt active while disabled");

    a_status_read: assert property (statusRead |=>
        !avs_waitrequest && avs_readdata[`PPP_ST_FAULT] == !$past(faultS_n) &&
        avs_readdata[`PPP_ST_PAPER_OUT] == $past(paperS) && avs_readdata[31:8] == 24'h000000)
        else $error("status read returned wrong levels");

    a_status_levels: assert property (statusRead |=>
        avs_readdata[`PPP_ST_ONLINE] == $past(onlineS) && avs_readdata[`PPP_ST_BUSY] == $past(busyS))
        else $error("online or busy misreported");

    a_wait_bound: assert property (accessStart |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("access not answered in one wait cycle");

    a_data_write: assert property (dataWrite |=> writeData_r == $past(avs_writedata[7:0]) ##1
        pdOut_r == $past(writeData_r))
        else $error("write data not stored or not driven");

    a_deselect_ignore: assert property (avs_write && parallel_port_select_n |=> $stable(control_r) &&
        $stable(writeData_r))
        else $error("write while deselected changed a register");

    a_pd_drive: assert property (!pdEnS_n [*2] |-> pdOe_r && pdOut_r == $past(writeData_r))
        else $error("data lines not driven from write data");

    a_pd_release: assert property (pdEnS_n |=> !printer_data_lines_oe)
        else $error("data lines driven while released");

    a_od_lines: assert property (1'b1 |=>
        {selectOe_r, initOe_r, autofeedOe_r, strobeOe_r} == $past(control_r[3:0]) &&
        data_latch_strobe_n_out == 1'b0)
        else $error("open-drain enables do not follow control");

    a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0) !rst_n |=>
        control_r == `PPP_RST_CONTROL && !parallel_irq && !printer_data_lines_oe && avs_waitrequest)
        else $error("reset left state uncleared");

endmodule

// >>> testbench/printer_model.sv
// Behavioural printer that latches strobed bytes and answers with busy and acknowledge
module printer_model (
    // Clock
    input wire logic mclk,
    // Lines from the port
    input wire logic strobeLine,
    input wire logic [7:0] dataLines,
    // Lines back to the port
    output logic busy,
    output logic ackN,
    output logic [7:0] lastByte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic strobePrev;
    int holdCnt;
    initial begin
        busy = 1'b0;
        ackN = 1'b1;
        lastByte = 8'h00;
        strobePrev = 1'b1;
        holdCnt = 0;
    end
    // Latch on the falling strobe, stay busy, pulse acknowledge low, then release both together
    always @(posedge mclk) begin
        strobePrev <= strobeLine;
        if (strobePrev && !strobeLine) begin
            lastByte <= dataLines;
            busy <= 1'b1;
            holdCnt <= 12;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
            ackN <= !(holdCnt <= 5 && holdCnt > 1);
            busy <= holdCnt > 1;
        end
    end
endmodule

// >>> testbench/printer_parallel_port_bench.sv
// Self-checking bench for the printer parallel port
`include "printer_parallel_port_consts.svh"
module printer_parallel_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rstN, avsRead, avsWrite, selN, paperOut, online, faultN, pdEnN, busy, ackN;
    logic waitReq, pdOe, strobeOut, strobeOe, afOut, afOe, inOut, inOe, slOut, slOe, irq, irqOe;
    logic [4:0] avsAddress;
    logic [3:0] avsBe;
    logic [31:0] avsWdata, rdData;
    logic [7:0] pdOut, replyByte, lastByte;
    int badCount, checksDone;
    // Open-drain lines sit at their pull-up unless pulled low; data lines are shared
    wire strobeLine = strobeOe ? strobeOut : 1'b1;
    wire afLine = afOe ? afOut : 1'b1;
    wire inLine = inOe ? inOut : 1'b1;
    wire slLine = slOe ? slOut : 1'b1;
    wire [7:0] pdLines = pdOe ? pdOut : replyByte;

    printer_parallel_port printer_parallel_port_i (.mclk(mclk), .rst_n(rstN), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe),
        .avs_readdata(rdData), .avs_waitrequest(waitReq), .parallel_port_select_n(selN), .ack_n(ackN),
        .busy(busy), .paper_out(paperOut), .printer_online(online), .fault_n(faultN),
        .pd_drive_enable_n(pdEnN), .printer_data_lines_in(pdLines), .printer_data_lines_out(pdOut),
        .printer_data_lines_oe(pdOe), .data_latch_strobe_n_out(strobeOut), .data_latch_strobe_n_oe(strobeOe),
        .autofeed_n_out(afOut), .autofeed_n_oe(afOe), .init_n_out(inOut), .init_n_oe(inOe),
        .printer_select_n_out(slOut), .printer_select_n_oe(slOe), .parallel_irq(irq), .parallel_irq_oe(irqOe));
    printer_model printer_model_i (.mclk(mclk), .strobeLine(strobeLine), .dataLines(pdLines), .busy(busy),
        .ackN(ackN), .lastByte(lastByte));

    // Clock at 200 MHz
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        badCount++;
        results();
    end
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask
    // One Avalon access; waitrequest is read as it stood before the edge, only the watchdog ends a hang
    task automatic busOp(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWdata <= {24'h000000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (waitReq !== 1'b0);
        q = rdData[7:0];
        chk1("bus answer", 1'b1, n == 2);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        busOp(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        busOp(1'b0, a, 8'h00, q);
        chk8(what, exp, q);
    endtask
    task automatic settle();
        repeat (5) @(posedge mclk);
    endtask

    task automatic testReset();
        chk8("oe lines", 8'h00, {1'b0, strobeOe, afOe, inOe, slOe, irq, irqOe, pdOe});
        rd(`PPP_OFF_CONTROL, 8'h00, "control");
        rd(`PPP_OFF_IRQ_STATUS, 8'h00, "irq status");
        rd(`PPP_OFF_IRQ_MASK, 8'h00, "irq mask");
        rd(5'h14, 8'h00, "unmapped");
    endtask
    task automatic testStatus();
        faultN <= 1'b0;
        paperOut <= 1'b1;
        online <= 1'b1;
        settle();
        rd(`PPP_OFF_STATUS, 8'h17, "status fault");
        faultN <= 1'b1;
        paperOut <= 1'b0;
        online <= 1'b0;
        settle();
        rd(`PPP_OFF_STATUS, 8'h10, "status clear");
        rd(`PPP_OFF_IRQ_STATUS, 8'h02, "fault event");
        chk1("masked irq", 1'b0, irq);
        wr(`PPP_OFF_IRQ_STATUS, 8'h07);
        rd(`PPP_OFF_IRQ_STATUS, 8'h00, "w1c");
    endtask
    task automatic testControl();
        wr(`PPP_OFF_CONTROL, 8'he6);
        settle();
        chk8("lines", 8'h09, {4'h0, strobeLine, afLine, inLine, slLine});
        rd(`PPP_OFF_CONTROL, 8'he6, "control");
        wr(`PPP_OFF_CONTROL, 8'h08);
        settle();
        chk8("lines", 8'h0e, {4'h0, strobeLine, afLine, inLine, slLine});
    endtask
    task automatic testData();
        pdEnN <= 1'b0;
        wr(`PPP_OFF_DATA, 8'ha5);
        settle();
        chk8("driven data", 8'ha5, pdLines);
        pdEnN <= 1'b1;
        replyByte <= 8'h3c;
        settle();
        chk1("data oe", 1'b0, pdOe);
        rd(`PPP_OFF_DATA, 8'h3c, "data in");
        pdEnN <= 1'b0;
    endtask
    task automatic testSelect();
        selN <= 1'b1;
        wr(`PPP_OFF_CONTROL, 8'h0e);
        rd(`PPP_OFF_CONTROL, 8'h00, "deselected read");
        selN <= 1'b0;
        rd(`PPP_OFF_CONTROL, 8'h08, "write ignored");
    endtask
    // Host side of one transfer: data, wait for not busy, strobe pulse
    task automatic printByte(input logic [7:0] d, input logic [7:0] ctl);
        logic [7:0] q;
        int n;
        wr(`PPP_OFF_DATA, d);
        n = 0;
        do begin
            busOp(1'b0, `PPP_OFF_STATUS, 8'h00, q);
            n++;
        end while (q[`PPP_ST_BUSY] !== 1'b0 && n < 20);
        wr(`PPP_OFF_CONTROL, ctl | 8'h01);
        wr(`PPP_OFF_CONTROL, ctl);
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        repeat (8) @(posedge mclk);
        chk8("printed byte", d, lastByte);
    endtask
    task automatic testIrq();
        wr(`PPP_OFF_IRQ_MASK, 8'h01);
        printByte(8'h5a, 8'h10);
        chk1("irq", 1'b1, irq);
        chk1("irq oe", 1'b1, irqOe);
        rd(`PPP_OFF_IRQ_STATUS, 8'h05, "ack event");
        wr(`PPP_OFF_IRQ_STATUS, 8'h07);
        settle();
        chk1("irq cleared", 1'b0, irq);
        printByte(8'hc3, 8'h00);
        chk1("irq disabled", 1'b0, irq);
        chk1("irq oe off", 1'b0, irqOe);
        rd(`PPP_OFF_IRQ_STATUS, 8'h05, "ack event");
    endtask

    // Main sequence: inputs at time zero, reset for 4 cycles, then the tests
    initial begin
        badCount = 0;
        checksDone = 0;
        rstN = 1'b0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsAddress = 5'h00;
        avsWdata = 32'h00000000;
        avsBe = 4'h1;
        selN = 1'b0;
        paperOut = 1'b0;
        online = 1'b0;
        faultN = 1'b1;
        pdEnN = 1'b1;
        replyByte = 8'h00;
        repeat (4) @(posedge mclk);
        rstN <= 1'b1;
        @(posedge mclk);
        testReset();
        testStatus();
        testControl();
        testData();
        testSelect();
        testIrq();
        results();
    end
endmodule
